// [cosc_map.vh]
// Register map, field positions and codes of the output/shutdown control.
// Assumes a 16-bit register port with word indices 0 to 4.
`ifndef COSC_MAP_VH
`define COSC_MAP_VH
`define COSC_IDX_SDG 3'h0
`define COSC_IDX_OEC 3'h1
`define COSC_IDX_DTC 3'h2
`define COSC_IDX_OMP 3'h3
`define COSC_IDX_STAT 3'h4
`define COSC_SDG_MASK 16'hd0ff
`define COSC_OEC_MASK_MULTI 16'hbfdf
`define COSC_OEC_MASK_SINGLE 16'h81df
`define COSC_DTC_MASK 16'h003f
`define COSC_OMP_MASK_MULTI 16'hf73f
`define COSC_OMP_MASK_SINGLE 16'hf02c
`define COSC_OEC_RESET 16'h0100
`define COSC_SDG_RESTART 15
`define COSC_SDG_GATEMODE 14
`define COSC_SDG_SWSD 12
`define COSC_OEC_SYNC 15
`define COSC_OEC_EN_HI 13
`define COSC_OEC_EN_LO 8
`define COSC_OEC_GSM_HI 7
`define COSC_OEC_GSM_LO 6
`define COSC_OEC_AUX_HI 4
`define COSC_OEC_AUX_LO 3
`define COSC_OEC_ICS_HI 2
`define COSC_OEC_ICS_LO 0
`define COSC_OMP_OUTPUT_WAIT_FOR_TRIGGER 15
`define COSC_OMP_OSC_HI 14
`define COSC_OMP_OSC_LO 12
`define COSC_OMP_OUTM_HI 10
`define COSC_OMP_OUTM_LO 8
`define COSC_OMP_POLARITY_GROUP_ACE 5
`define COSC_OMP_POLARITY_GROUP_BDF 4
`define COSC_OMP_PSSA_HI 3
`define COSC_OMP_PSSA_LO 2
`define COSC_OMP_PSSB_HI 1
`define COSC_OMP_PSSB_LO 0
`define COSC_STAT_TRIG 7
`define COSC_STAT_SDEVT 4
`define COSC_STAT_CAPTURE_DISABLE_STATUS 2
`define COSC_GSM_LEVEL 2'h0
`define COSC_GSM_RISE 2'h1
`define COSC_GSM_FALL 2'h2
`define COSC_AUX_OFF 2'h0
`define COSC_AUX_ROLL 2'h1
`define COSC_AUX_MODE 2'h2
`define COSC_AUX_EVT 2'h3
`define COSC_OUTM_STEER 3'h0
`define COSC_OUTM_PUSHPULL 3'h1
`define COSC_OUTM_HALFBR 3'h2
`define COSC_OUTM_BDC_REV 3'h4
`define COSC_OUTM_BDC_FWD 3'h5
`define COSC_OUTM_SCAN 3'h6
`define COSC_PSS_ACTIVE 2'h3
`define COSC_PSS_INACTIVE 2'h2
`endif

// [cosc_ctrl.v]
// Output shutdown, steering, dead time and capture gating control stage.
// Assumes the time base, PWM generator and capture edge logic sit outside
// and hand in their signals synchronous to clock_i.
// Operation
// - With restart enable, shutdown status clears at next period after input leaves.
// - Gate mode set delays shutdown to next rollover; clear acts at once.
// - Software shutdown bit forces the event, still obeying gate mode.
// - Eight source enables admit comparators, compare outputs, logic cell, faults.
// - Output enable sync applies enable changes at next rollover.
// - Enable bit hands pin to module; output A enable resets to one.
// - Capture gate modes: level, rising enables, falling disables, 11 reserved.
// - Aux output: off, rollover, mode signal, capture/compare event.
// - Capture source: pin, comparators one to three, logic cells one to four.
// - Dead-time count N inserts N clocks; zero disables.
// - Hold bit in triggered operation keeps enabled pins undriven until trigger.
// - One-shot count N extends a triggered run by N periods.
// - Mode 000 steer, 001 push-pull, 010 half-bridge; 011 and 111 reserved.
// - Mode 100 reverse brushed DC, 101 forward, 110 output scan.
// - Polarity bits make ACE and BDF pin groups active-low when set.
// - Shutdown state 11 drives active, 10 inactive, 0x high impedance.
// - Dead time, B-F enables, second polarity, mode exist in multi-output only.
// - Shutdown status reads one while outputs are held in shutdown.
// - Capture disable status set blocks capture events.
// - Trigger enable holds timer in reset until a trigger.
// - In one-shot mode the run length follows the extend count.
`default_nettype none
`include "cosc_map.vh"

module cosc_ctrl #(
   parameter MULTI = 1
) (
   // Clock and reset.
   input wire clock_i,
   input wire rst_n_i,
   // Register port.
   input wire [2:0] addr_i,
   input wire [15:0] wdata_i,
   input wire wr_i,
   input wire rd_i,
   output reg [15:0] rdata_o,
   // Time base and generator interface.
   input wire rollover_i,
   input wire trigger_enable_i,
   input wire one_shot_enable_i,
   input wire trigger_set_i,
   input wire trigger_clear_i,
   input wire timer_mode_i,
   input wire pwm_a_i,
   input wire pwm_b_i,
   input wire mode_aux_i,
   input wire ccp_event_i,
   input wire direction_i,
   input wire [1:0] scan_sel_i,
   // Shutdown sources, order: comparator_one..3, oc x, oc y, logic cell, fault a, b.
   input wire [7:0] shutdown_src_i,
   // Capture sources.
   input wire capture_input_pin_i,
   input wire [2:0] comparator_i,
   input wire [3:0] logic_cell_output_i,
   input wire gate_src_i,
   input wire gate_arm_i,
   // Pins, groups A..F; enables low while the module drives a pin.
   output reg [5:0] compare_output_pin_o,
   output reg [5:0] compare_output_oe_n_o,
   output reg [5:0] pin_owned_o,
   output reg capture_o,
   output reg aux_o,
   output reg timer_hold_o,
   output reg shutdown_event_status_o
);

   ////////////////////////////////////////////////////////////////////////
   // Registers.
   reg [15:0] sdg_r;
   reg [15:0] oec_r;
   reg [15:0] dtc_r;
   reg [15:0] omp_r;
   reg [5:0] en_live_r;
   reg sd_r;
   reg sd_pend_r;
   reg capture_disable_status_r;
   reg gate_d_r;
   reg armed_r;
   reg trig_r;
   reg [2:0] os_cnt_r;
   reg cap_d_r;
   reg [5:0] dt_cnt_a_r;
   reg [5:0] dt_cnt_b_r;
   reg [5:0] drv_r;

   wire [15:0] oec_mask;
   wire [15:0] omp_mask;
   assign oec_mask = MULTI ? `COSC_OEC_MASK_MULTI : `COSC_OEC_MASK_SINGLE;
   assign omp_mask = MULTI ? `COSC_OMP_MASK_MULTI : `COSC_OMP_MASK_SINGLE;

   // Single instances lose B-F enables, dead time, mode and second
   // polarity: the masks below simply never let those bits store.
   always @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         sdg_r <= 16'h0000;
         oec_r <= `COSC_OEC_RESET;
         dtc_r <= 16'h0000;
         omp_r <= 16'h0000;
      end else if (wr_i) begin
         case (addr_i)
            `COSC_IDX_SDG: sdg_r <= wdata_i & `COSC_SDG_MASK;
            `COSC_IDX_OEC: oec_r <= wdata_i & oec_mask;
            `COSC_IDX_DTC: dtc_r <= MULTI ? (wdata_i & `COSC_DTC_MASK) :
               16'h0000;
            `COSC_IDX_OMP: omp_r <= wdata_i & omp_mask;
            default: ;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Shutdown: sources, software force and gate timing.
   wire sd_req;
   wire sd_now;
   wire sd_clr_wr;
   assign sd_req = (|(shutdown_src_i & sdg_r[7:0])) |
      sdg_r[`COSC_SDG_SWSD];
   assign sd_now = (sd_req | sd_pend_r) & (~sdg_r[`COSC_SDG_GATEMODE] |
      rollover_i);
   assign sd_clr_wr = wr_i & (addr_i == `COSC_IDX_STAT) &
      ~wdata_i[`COSC_STAT_SDEVT];

   // A new event wins over a clear in the same cycle.
   always @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         sd_r <= 1'b0;
         sd_pend_r <= 1'b0;
      end else begin
         sd_pend_r <= (sd_req | sd_pend_r) & sdg_r[`COSC_SDG_GATEMODE] &
            ~rollover_i & ~sd_r;
         if (sd_now) begin
            sd_r <= 1'b1;
            sd_pend_r <= 1'b0;
         end else if (sd_r & sdg_r[`COSC_SDG_RESTART] & rollover_i) begin
            sd_r <= 1'b0;
         end else if (sd_r & sd_clr_wr) begin
            sd_r <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Output enable updates, immediate or at rollover.
   always @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         en_live_r <= 6'h01;
      end else if (~oec_r[`COSC_OEC_SYNC] | rollover_i) begin
         en_live_r <= oec_r[`COSC_OEC_EN_HI:`COSC_OEC_EN_LO];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Capture source and gating.
   function cosc_pick;
      input [2:0] sel;
      input pin;
      input [2:0] cmp;
      input [3:0] logic_cell_output;
      begin
         case (sel)
            3'h0: cosc_pick = pin;
            3'h1: cosc_pick = cmp[0];
            3'h2: cosc_pick = cmp[1];
            3'h3: cosc_pick = cmp[2];
            3'h4: cosc_pick = logic_cell_output[0];
            3'h5: cosc_pick = logic_cell_output[1];
            3'h6: cosc_pick = logic_cell_output[2];
            default: cosc_pick = logic_cell_output[3];
         endcase
      end
   endfunction

   wire cap_src;
   wire [1:0] gsm;
   // Software gating goes through the same path as the hardware gate.
   wire gate_lvl;
   assign cap_src = cosc_pick(oec_r[`COSC_OEC_ICS_HI:`COSC_OEC_ICS_LO],
      capture_input_pin_i, comparator_i, logic_cell_output_i);
   assign gsm = oec_r[`COSC_OEC_GSM_HI:`COSC_OEC_GSM_LO];
   assign gate_lvl = gate_src_i & ~sdg_r[`COSC_SDG_SWSD];

   always @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         capture_disable_status_r <= 1'b0;
         gate_d_r <= 1'b0;
         armed_r <= 1'b0;
         cap_d_r <= 1'b0;
         capture_o <= 1'b0;
      end else begin
         gate_d_r <= gate_lvl;
         cap_d_r <= cap_src;
         capture_o <= cap_src & ~cap_d_r & ~capture_disable_status_r;
         case (gsm)
            `COSC_GSM_LEVEL: capture_disable_status_r <= ~gate_lvl;
            `COSC_GSM_RISE: begin
               if (gate_arm_i) armed_r <= 1'b1;
               else if (armed_r & gate_lvl & ~gate_d_r) begin
                  capture_disable_status_r <= 1'b0;
                  armed_r <= 1'b0;
               end
            end
            `COSC_GSM_FALL: begin
               if (gate_arm_i) armed_r <= 1'b1;
               else if (armed_r & ~gate_lvl & gate_d_r) begin
                  capture_disable_status_r <= 1'b1;
                  armed_r <= 1'b0;
               end
            end
            default: ; // Reserved code leaves gating as it stands.
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Trigger run and one-shot extension.
   always @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         trig_r <= 1'b0;
         os_cnt_r <= 3'h0;
      end else if (~trigger_enable_i) begin
         trig_r <= 1'b0;
         os_cnt_r <= 3'h0;
      end else if (trigger_set_i) begin
         trig_r <= 1'b1;
         os_cnt_r <= omp_r[`COSC_OMP_OSC_HI:`COSC_OMP_OSC_LO];
      end else if (trigger_clear_i) begin
         trig_r <= 1'b0;
      end else if (trig_r & one_shot_enable_i & rollover_i) begin
         if (os_cnt_r == 3'h0) trig_r <= 1'b0;
         else os_cnt_r <= os_cnt_r - 3'h1;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Dead time: rising edges delayed by N clocks.
   wire [5:0] dt_n;
   reg dt_a;
   reg dt_b;
   assign dt_n = dtc_r[5:0];
   always @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         dt_cnt_a_r <= 6'h00;
         dt_cnt_b_r <= 6'h00;
      end else begin
         dt_cnt_a_r <= ~pwm_a_i ? 6'h00 :
            (dt_cnt_a_r < dt_n ? dt_cnt_a_r + 6'h01 : dt_cnt_a_r);
         dt_cnt_b_r <= ~pwm_b_i ? 6'h00 :
            (dt_cnt_b_r < dt_n ? dt_cnt_b_r + 6'h01 : dt_cnt_b_r);
      end
   end
   always @* begin
      dt_a = pwm_a_i & (dt_cnt_a_r >= dt_n);
      dt_b = pwm_b_i & (dt_cnt_b_r >= dt_n);
   end

   ////////////////////////////////////////////////////////////////////////
   // Output mode steering, active-high before polarity.
   reg [5:0] act;
   always @* begin
      act = 6'h00;
      case (omp_r[`COSC_OMP_OUTM_HI:`COSC_OMP_OUTM_LO])
         `COSC_OUTM_STEER: act = {6{pwm_a_i}};
         `COSC_OUTM_PUSHPULL: act = {4'h0, ~pwm_a_i, pwm_a_i};
         `COSC_OUTM_HALFBR: act = {4'h0, dt_b, dt_a};
         `COSC_OUTM_BDC_REV: act = {4'h0, pwm_a_i, 1'b0} |
            {2'h0, 4'h1 & {4{~direction_i}}} ;
         `COSC_OUTM_BDC_FWD: act = {2'h0, pwm_a_i, 2'h0, 1'b1};
         `COSC_OUTM_SCAN: act = {5'h00, pwm_a_i} << scan_sel_i;
         default: act = 6'h00;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////
   // Pin drive: shutdown states, polarity, trigger hold, ownership.
   wire [1:0] pss_a;
   wire [1:0] pss_b;
   wire pol_a;
   wire pol_b;
   wire hold;
   assign pss_a = omp_r[`COSC_OMP_PSSA_HI:`COSC_OMP_PSSA_LO];
   assign pss_b = omp_r[`COSC_OMP_PSSB_HI:`COSC_OMP_PSSB_LO];
   assign pol_a = omp_r[`COSC_OMP_POLARITY_GROUP_ACE];
   assign pol_b = omp_r[`COSC_OMP_POLARITY_GROUP_BDF];
   assign hold = omp_r[`COSC_OMP_OUTPUT_WAIT_FOR_TRIGGER] & trigger_enable_i & ~trig_r;

   genvar g;
   generate
      for (g = 0; g < 6; g = g + 1) begin : pin_g
         wire [1:0] pss;
         wire pol;
         wire lvl;
         wire tri_st;
         assign pss = (g % 2 == 0) ? pss_a : pss_b;
         assign pol = (g % 2 == 0) ? pol_a : pol_b;
         assign lvl = sd_r ? (pss == `COSC_PSS_ACTIVE) : act[g];
         assign tri_st = sd_r & ~pss[1];
         always @(posedge clock_i or negedge rst_n_i) begin
            if (!rst_n_i) begin
               compare_output_pin_o[g] <= 1'b0;
               compare_output_oe_n_o[g] <= 1'b1;
               pin_owned_o[g] <= 1'b0;
            end else begin
               compare_output_pin_o[g] <= lvl ^ pol;
               compare_output_oe_n_o[g] <= ~en_live_r[g] | tri_st |
                  hold;
               pin_owned_o[g] <= en_live_r[g];
            end
         end
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////
   // Aux output, timer hold, status and read port.
   always @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         aux_o <= 1'b0;
         timer_hold_o <= 1'b0;
         shutdown_event_status_o <= 1'b0;
         rdata_o <= 16'h0000;
      end else begin
         case (oec_r[`COSC_OEC_AUX_HI:`COSC_OEC_AUX_LO])
            `COSC_AUX_ROLL: aux_o <= rollover_i;
            `COSC_AUX_MODE: aux_o <= mode_aux_i;
            `COSC_AUX_EVT: aux_o <= ccp_event_i & ~timer_mode_i;
            default: aux_o <= 1'b0;
         endcase
         timer_hold_o <= trigger_enable_i & ~trig_r;
         shutdown_event_status_o <= sd_r;
         rdata_o <= 16'h0000;
         if (rd_i) begin
            case (addr_i)
               `COSC_IDX_SDG: rdata_o <= sdg_r;
               `COSC_IDX_OEC: rdata_o <= oec_r;
               `COSC_IDX_DTC: rdata_o <= dtc_r;
               `COSC_IDX_OMP: rdata_o <= omp_r;
               `COSC_IDX_STAT: rdata_o <= {8'h00, trig_r, 2'h0, sd_r, 1'b0,
                  capture_disable_status_r, 2'h0};
               default: rdata_o <= 16'h0000;
            endcase
         end
      end
   end

endmodule
`default_nettype wire

// [cosc_ctrl_monitor.sv]
// Concurrent checks on the ports of the output shutdown control stage.
// Assumes the register port follows the one-cycle strobe protocol.
`default_nettype none
`include "cosc_map.vh"
module cosc_ctrl_monitor #(
   parameter MULTI = 1
) (
   // Clock, reset and register port.
   input wire logic clock_i,
   input wire logic rst_n_i,
   input wire logic [2:0] addr_i,
   input wire logic [15:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   input wire logic [15:0] rdata_o,
   // Time base and pin side.
   input wire logic rollover_i,
   input wire logic [5:0] compare_output_pin_o,
   input wire logic [5:0] compare_output_oe_n_o,
   input wire logic [5:0] pin_owned_o,
   input wire logic capture_o,
   input wire logic aux_o,
   input wire logic shutdown_event_status_o
);
   logic [15:0] sdg_r;
   logic [15:0] oec_r;
   logic [15:0] omp_r;
   wire logic st_wr = wr_i && addr_i == `COSC_IDX_STAT;
   wire logic sd = shutdown_event_status_o;
   wire logic sd_wr = wr_i && addr_i == `COSC_IDX_SDG;
   ////////////////////////////////////////////////////////////////////////
   // Shadow copies of the control words, since the checks need settings.
   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         sdg_r <= 16'h0000;
         oec_r <= `COSC_OEC_RESET;
         omp_r <= 16'h0000;
      end else if (wr_i) begin
         if (addr_i == `COSC_IDX_SDG) sdg_r <= wdata_i;
         if (addr_i == `COSC_IDX_OEC) oec_r <= wdata_i;
         if (addr_i == `COSC_IDX_OMP) omp_r <= wdata_i;
      end
   end
   ////////////////////////////////////////////////////////////////////////
   // All checks share the one clock and reset of the block.
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (!rst_n_i);
   a_read_idle_zero: assert property (!$past(rd_i) |-> rdata_o == 16'h0000)
      else $error("read data outside the answer cycle");
   a_swsd_at_once: assert property (sd_wr && wdata_i[12] && !wdata_i[14]
      |-> ##[1:3] sd) else $error("software shutdown not taken at once");
   a_gated_wait: assert property ($rose(sd) && $past(sdg_r[14])
      |-> $past(rollover_i) || $past(rollover_i, 2))
      else $error("gated shutdown began off a rollover");
   a_status_held: assert property (sd && !sdg_r[15] && !st_wr
      && !$past(st_wr) |=> sd)
      else $error("shutdown status left without software");
   a_clear_cause: assert property ($fell(sd)
      |-> $past(rollover_i, 2) || $past(st_wr, 2))
      else $error("shutdown status cleared without cause");
   a_drive_owned: assert property ((~compare_output_oe_n_o & ~pin_owned_o) == 6'h00)
      else $error("pin driven while not owned");
   a_pss_state: assert property (sd && $past(sd) && pin_owned_o[0]
      && $past(pin_owned_o[0]) && $stable(omp_r) && $past(omp_r) == $past(omp_r, 2)
      |-> (omp_r[3] ? !compare_output_oe_n_o[0]
      && compare_output_pin_o[0] == (omp_r[2] ^ omp_r[5])
      : compare_output_oe_n_o[0])) else $error("pin A shutdown state wrong");
   a_aux_off_quiet: assert property (oec_r[4:3] == `COSC_AUX_OFF
      && $past(oec_r[4:3]) == `COSC_AUX_OFF |-> !aux_o)
      else $error("aux output active while off");
   a_capture_pulse: assert property (capture_o |=> !capture_o)
      else $error("capture pulse longer than one cycle");
   // Main scenarios that the run should reach.
   c_shutdown: cover property ($rose(sd));
   c_capture: cover property (capture_o);
   c_drive_a: cover property ($fell(compare_output_oe_n_o[0]));
endmodule

bind cosc_ctrl cosc_ctrl_monitor #(.MULTI(MULTI)) u_mon (.clock_i, .rst_n_i,
   .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .rollover_i,
   .compare_output_pin_o, .compare_output_oe_n_o, .pin_owned_o, .capture_o,
   .aux_o, .shutdown_event_status_o);
`default_nettype wire

// [cosc_load.sv]
// Model of the power stage gate inputs hanging on the compare pins.
// Assumes each gate input carries a weak pull-down when left undriven.
`default_nettype none
module cosc_load (
   // Pin levels and enables from the block.
   input wire logic [5:0] pin_i,
   input wire logic [5:0] oe_n_i,
   // Level seen by each gate.
   output logic [5:0] gate_o
);
   timeunit 1ns;
   timeprecision 100ps;
   // A released pin falls to the pull-down, so no stale level survives.
   assign gate_o = pin_i & ~oe_n_i;
endmodule
`default_nettype wire

// [cosc_ctrl_tb.sv]
// Self-checking bench for the output shutdown control stage.
// Assumes the register map header and a 40 MHz clock.
`default_nettype none
`include "cosc_map.vh"
module cosc_ctrl_tb;
   timeunit 1ns;
   timeprecision 100ps;
   logic clock_i, rst_n_i, wr_i, rd_i, rollover_i, trigger_enable_i;
   logic one_shot_enable_i, trigger_set_i, trigger_clear_i, timer_mode_i;
   logic pwm_a_i, pwm_b_i, mode_aux_i, ccp_event_i, direction_i, gate_src_i;
   logic capture_input_pin_i, gate_arm_i, capture_o, aux_o, timer_hold_o;
   logic shutdown_event_status_o;
   logic [2:0] addr_i, comparator_i;
   logic [15:0] wdata_i, rdata_o;
   logic [1:0] scan_sel_i;
   logic [7:0] shutdown_src_i;
   logic [3:0] logic_cell_output_i;
   logic [5:0] compare_output_pin_o, compare_output_oe_n_o, pin_owned_o, gate;
   int n_mismatch = 0;
   int n_tests = 0;
   int k, n0, n1;
   cosc_ctrl #(.MULTI(1)) dut (.clock_i, .rst_n_i, .addr_i, .wdata_i, .wr_i,
      .rd_i, .rdata_o, .rollover_i, .trigger_enable_i, .one_shot_enable_i,
      .trigger_set_i, .trigger_clear_i, .timer_mode_i, .pwm_a_i, .pwm_b_i,
      .mode_aux_i, .ccp_event_i, .direction_i, .scan_sel_i, .shutdown_src_i,
      .capture_input_pin_i, .comparator_i, .logic_cell_output_i, .gate_src_i,
      .gate_arm_i, .compare_output_pin_o, .compare_output_oe_n_o,
      .pin_owned_o, .capture_o, .aux_o, .timer_hold_o,
      .shutdown_event_status_o);
   cosc_load u_load (.pin_i(compare_output_pin_o),
      .oe_n_i(compare_output_oe_n_o), .gate_o(gate));
   ////////////////////////////////////////////////////////////////////////
   // Clock at 25 ns.
   always #12.5 clock_i = ~clock_i;
   // Bus and compare helpers; the master moves only just after an edge.
   task automatic tick(input int n);
      repeat (n) @(posedge clock_i);
      #1;
   endtask
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      n_tests++;
      if (got !== exp) begin
         n_mismatch++;
         $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [2:0] a, input logic [15:0] d);
      @(posedge clock_i);
      addr_i <= a;
      wdata_i <= d;
      wr_i <= 1'b1;
      @(posedge clock_i);
      wr_i <= 1'b0;
   endtask
   task automatic rd(input logic [2:0] a, input logic [15:0] exp);
      @(posedge clock_i);
      addr_i <= a;
      rd_i <= 1'b1;
      @(posedge clock_i);
      rd_i <= 1'b0;
      #1 chk(rdata_o, exp);
   endtask
   // Event pulse on rollover, compare event and mode signal.
   task automatic ev(input logic [2:0] v);
      @(posedge clock_i);
      {rollover_i, ccp_event_i, mode_aux_i} <= v;
      @(posedge clock_i);
      {rollover_i, ccp_event_i, mode_aux_i} <= 3'b000;
   endtask
   // Counts capture or aux pulses over five cycles, ending on an edge.
   task automatic seen(output int c);
      c = 0;
      repeat (5) begin
         #1 if ((capture_o | aux_o) === 1'b1) c++;
         @(posedge clock_i);
      end
   endtask
   task automatic finish_test;
      $display("compares %0d, mismatches %0d", n_tests, n_mismatch);
      if (n_mismatch == 0 && n_tests > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////
   // Reset values, masks of unused bits, an unmapped word, all modes.
   task automatic t_regs;
      logic [15:0] m [4] = '{`COSC_SDG_MASK, `COSC_OEC_MASK_MULTI,
         `COSC_DTC_MASK, `COSC_OMP_MASK_MULTI};
      rd(1, `COSC_OEC_RESET);
      for (int i = 0; i < 6; i++) if (i != 1) rd(i, 16'h0000);
      for (int i = 0; i < 4; i++) begin
         wr(i, 16'hffff);
         rd(i, m[i]);
         wr(i, (i == 1) ? `COSC_OEC_RESET : 16'h0000);
      end
      wr(5, 16'hffff);
      rd(5, 16'h0000);
      for (int i = 0; i < 8; i++) begin
         wr(3, 16'(i) << 8);
         rd(3, 16'(i) << 8);
      end
      wr(3, 16'h0000);
      wr(4, 16'h0000);
      $display("test regs done");
   endtask
   // Software shutdown, gate mode timing and automatic restart.
   task automatic t_swsd;
      wr(0, 16'h1000);
      tick(3);
      chk(shutdown_event_status_o, 1'b1);
      wr(0, 16'h0000);
      tick(3);
      chk(shutdown_event_status_o, 1'b1);
      rd(4, 16'h0010);
      wr(4, 16'h0000);
      tick(2);
      chk(shutdown_event_status_o, 1'b0);
      wr(0, 16'h5000);
      tick(5);
      chk(shutdown_event_status_o, 1'b0);
      ev(3'b100);
      tick(2);
      chk(shutdown_event_status_o, 1'b1);
      wr(0, 16'hc000);
      ev(3'b100);
      tick(2);
      chk(shutdown_event_status_o, 1'b0);
      wr(0, 16'h0000);
      $display("test swsd done");
   endtask
   // Each source enable admits its own source and no other.
   task automatic t_src;
      for (int i = 0; i < 8; i++) begin
         wr(0, 16'h0001 << i);
         shutdown_src_i <= ~(8'h01 << i);
         tick(3);
         chk(shutdown_event_status_o, 1'b0);
         @(posedge clock_i);
         shutdown_src_i <= 8'hff;
         tick(3);
         chk(shutdown_event_status_o, 1'b1);
         @(posedge clock_i);
         shutdown_src_i <= 8'h00;
         wr(4, 16'h0000);
         tick(2);
         chk(shutdown_event_status_o, 1'b0);
      end
      wr(0, 16'h0000);
      $display("test src done");
   endtask
   // Shutdown pin states under both polarities, seen at the load.
   task automatic t_pss;
      logic [15:0] cfg [5] = '{16'h000c, 16'h0008, 16'h002c, 16'h0000,
         16'h0004};
      logic [1:0] exp [5] = '{2'b01, 2'b00, 2'b00, 2'b10, 2'b10};
      wr(0, 16'h1000);
      for (int i = 0; i < 5; i++) begin
         wr(3, cfg[i]);
         tick(3);
         chk({compare_output_oe_n_o[0], gate[0]}, exp[i]);
      end
      wr(0, 16'h0000);
      wr(4, 16'h0000);
      wr(3, 16'h0000);
      $display("test pss done");
   endtask
   // Normal drive, polarity, release and synchronised enables.
   task automatic t_enable;
      pwm_a_i <= 1'b1;
      tick(3);
      chk({compare_output_oe_n_o[0], gate[0]}, 2'b01);
      wr(3, 16'h0020);
      tick(3);
      chk({compare_output_oe_n_o[0], gate[0]}, 2'b00);
      wr(3, 16'h0000);
      wr(1, 16'h0000);
      tick(3);
      chk({pin_owned_o[0], compare_output_oe_n_o[0]}, 2'b01);
      wr(1, 16'h8000);
      wr(1, 16'h8100);
      tick(4);
      chk(pin_owned_o[0], 1'b0);
      ev(3'b100);
      tick(2);
      chk(pin_owned_o[0], 1'b1);
      wr(1, `COSC_OEC_RESET);
      $display("test enable done");
   endtask
   // Rising edge delay on pin A in half-bridge mode.
   task automatic lat(output int n);
      @(posedge clock_i);
      pwm_a_i <= 1'b0;
      tick(8);
      @(posedge clock_i);
      pwm_a_i <= 1'b1;
      n = 0;
      do begin
         @(posedge clock_i);
         #1 n++;
      end while (compare_output_pin_o[0] !== 1'b1 && n < 30);
   endtask
   task automatic t_dead;
      wr(3, 16'h0200);
      wr(2, 16'h0000);
      lat(n0);
      for (int d = 1; d < 4; d += 2) begin
         wr(2, 16'(d));
         lat(n1);
         chk(16'(n1 - n0), 16'(d));
      end
      wr(2, 16'h0000);
      wr(3, 16'h0000);
      $display("test dead done");
   endtask
   // Capture source selection and level gating.
   task automatic t_capture;
      for (int c = 0; c < 8; c++) begin
         wr(1, `COSC_OEC_RESET | 16'(c));
         {logic_cell_output_i, comparator_i, capture_input_pin_i} <= ~(8'h01 << c);
         seen(k);
         chk(16'(k), 16'h0000);
         {logic_cell_output_i, comparator_i, capture_input_pin_i} <= 8'hff;
         seen(k);
         chk(16'(k), 16'h0001);
         {logic_cell_output_i, comparator_i, capture_input_pin_i} <= 8'h00;
      end
      gate_src_i <= 1'b0;
      wr(1, `COSC_OEC_RESET);
      capture_input_pin_i <= 1'b1;
      seen(k);
      chk(16'(k), 16'h0000);
      rd(4, 16'h0004);
      @(posedge clock_i);
      {gate_src_i, capture_input_pin_i} <= 2'b10;
      $display("test capture done");
   endtask
   // Aux output codes, including the quiet timer mode case.
   task automatic t_aux;
      logic [15:0] w [5] = '{16'h0108, 16'h0110, 16'h0118, 16'h0118,
         16'h0100};
      logic [2:0] e [5] = '{3'b100, 3'b001, 3'b010, 3'b010, 3'b111};
      for (int i = 0; i < 5; i++) begin
         timer_mode_i <= (i == 3);
         wr(1, w[i]);
         ev(e[i]);
         seen(k);
         chk(16'(k), 16'(i < 3));
      end
      timer_mode_i <= 1'b0;
      $display("test aux done");
   endtask
   // Triggered operation with output hold until the trigger.
   task automatic t_trig;
      trigger_enable_i <= 1'b1;
      wr(3, 16'h8000);
      tick(3);
      chk({timer_hold_o, compare_output_oe_n_o[0]}, 2'b11);
      @(posedge clock_i);
      trigger_set_i <= 1'b1;
      @(posedge clock_i);
      trigger_set_i <= 1'b0;
      tick(3);
      chk({timer_hold_o, compare_output_oe_n_o[0]}, 2'b00);
      @(posedge clock_i);
      trigger_clear_i <= 1'b1;
      @(posedge clock_i);
      trigger_clear_i <= 1'b0;
      tick(3);
      chk(timer_hold_o, 1'b1);
      $display("test trig done");
   endtask
   ////////////////////////////////////////////////////////////////////////
   // Reset for four cycles, then the tests in turn.
   initial begin
      clock_i = 1'b0;
      rst_n_i = 1'b0;
      {wr_i, rd_i, rollover_i, trigger_enable_i, one_shot_enable_i} = '0;
      {trigger_set_i, trigger_clear_i, timer_mode_i, pwm_a_i, pwm_b_i} = '0;
      {mode_aux_i, ccp_event_i, direction_i, capture_input_pin_i} = '0;
      {gate_arm_i, addr_i, comparator_i, wdata_i, scan_sel_i} = '0;
      {shutdown_src_i, logic_cell_output_i} = '0;
      gate_src_i = 1'b1;
      repeat (4) @(posedge clock_i);
      rst_n_i <= 1'b1;
      t_regs;
      t_swsd;
      t_src;
      t_pss;
      t_enable;
      t_dead;
      t_capture;
      t_aux;
      t_trig;
      finish_test;
   end
   // Watchdog well beyond the few hundred cycles the tests need.
   initial begin
      #500000;
      n_mismatch++;
      finish_test;
   end
endmodule
`default_nettype wire
